// ===== rtl/ssf_cfg.svh
// constants of the select/shift front end
// assumes inclusion by bare name from the package and modules
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH
`define SSF_BYTE_W 8
`define SSF_BIT_CNT_W 3
`define SSF_LAST_BIT 3'h7
`define SSF_PAGES 64
`define SSF_PAGE_BYTES 16
`define SSF_PAGE_W 6
`define SSF_IDX_W 4
`define SSF_ADDR_MSB_BIT 3
`define SSF_FIFO_DEPTH 8
`define SSF_BYTE_NO_W 2
`define SSF_BYTE_NO_ADDR 2'h1
`define SSF_BYTE_NO_DATA 2'h2
`endif

// ===== rtl/ssf_front.sv
// fifo and select/shift front end of a serial memory as spi target
// assumes one 100 MHz clk_sys, synchronous active-low rstn, pins asynchronous
//
// Summary of operation
// - sample data input on serial clock rise
// - change data output only after clock fall
// - select on select falling with clock low
// - deselect on select rising with clock low
// - release output at once when deselected
// - start deselected with output released
// - ignore select changes while clock high
// - array of 64 pages by 16 bytes; the address reaches only pages 0 to 31, top page bit held zero
// - respond only while selected, from select fall to select rise, both taken with clock low
// - shift bytes most significant bit first
// - first eight bits form instruction byte
`timescale 1ns/10ps
`include "ssf_cfg.svh"

module ssf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `SSF_FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  // pointer and fill count update
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? ((wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
endmodule // ssf_fifo

module ssf_front (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_n,
  output ssf_pkg::ssf_rx_t rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [`SSF_BYTE_W-1:0] tx_byte,
  output logic tx_take,
  output ssf_pkg::ssf_addr_t addr,
  output logic selected,
  output logic overflow
);
  import ssf_pkg::*;

  logic [2:0] sck_m_q, sel_m_q;
  logic [1:0] sdi_m_q;
  logic sck_p_q, sel_p_q;
  logic sck_s, sel_s, sdi_s, rise, fall, sel_fall, sel_rise;
  ssf_state_t st_q, st_d;
  logic [`SSF_BIT_CNT_W-1:0] bit_q, bit_d;
  logic [`SSF_BYTE_W-1:0] shin_q, shin_d, shout_q, shout_d, new_byte;
  logic [`SSF_BYTE_NO_W-1:0] bno_q, bno_d;
  logic amsb_q, amsb_d, sdo_q, sdo_d, oe_n_q, oe_n_d, take_q, take_d, ovf_q, ovf_d;
  ssf_addr_t addr_q, addr_d;
  logic byte_done, in_ready, push;
  ssf_rx_t item;

  // two-stage synchronisers; stage 2 feeds the logic, plus a history copy for clock and select only
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sck_m_q <= 3'h0;
      sel_m_q <= 3'h7;
      sdi_m_q <= 2'h0;
    end else begin
      sck_m_q <= {sck_m_q[1:0], sck_i};
      sel_m_q <= {sel_m_q[1:0], sel_n_i};
      sdi_m_q <= {sdi_m_q[0], sdi_i};
    end
  end

  // edges seen on the synchronised pins
  always_comb begin
    sck_s = sck_m_q[1];
    sel_s = sel_m_q[1];
    sdi_s = sdi_m_q[1];
    sck_p_q = sck_m_q[2];
    sel_p_q = sel_m_q[2];
    rise = sck_s && !sck_p_q;
    fall = !sck_s && sck_p_q;
    sel_fall = !sel_s && sel_p_q;
    sel_rise = sel_s && !sel_p_q;
  end

  // selection, shifting and address tracking
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    shin_d = shin_q;
    shout_d = shout_q;
    bno_d = bno_q;
    amsb_d = amsb_q;
    addr_d = addr_q;
    sdo_d = sdo_q;
    take_d = 1'b0;
    ovf_d = ovf_q;
    new_byte = {shin_q[`SSF_BYTE_W-2:0], sdi_s};
    byte_done = 1'b0;
    // select edges honoured only with clock low
    if (!sck_s && sel_fall && st_q == SSF_IDLE) begin
      st_d = SSF_SEL;
      bit_d = '0;
      bno_d = '0;
      shout_d = '0;
      ovf_d = 1'b0;
    end else if (!sck_s && sel_rise) begin
      st_d = SSF_IDLE;
    end else if (st_q == SSF_SEL) begin
      if (rise) begin
        shin_d = new_byte;
        bit_d = bit_q + 1'b1;
        byte_done = (bit_q == `SSF_LAST_BIT);
      end
      if (fall) begin
        take_d = (bit_q == '0);
        sdo_d = (bit_q == '0) ? tx_byte[`SSF_BYTE_W-1] : shout_q[`SSF_BYTE_W-1];
        shout_d = (bit_q == '0) ? {tx_byte[`SSF_BYTE_W-2:0], 1'b0} : {shout_q[`SSF_BYTE_W-2:0], 1'b0};
      end
    end
    if (byte_done) begin
      if (bno_q == '0) begin
        amsb_d = new_byte[`SSF_ADDR_MSB_BIT];
      end else if (bno_q == `SSF_BYTE_NO_ADDR) begin
        // top page bit stays zero: only one address bit rides in the instruction
        addr_d = ssf_addr_t'({1'b0, amsb_q, new_byte});
      end else begin
        addr_d.idx = addr_q.idx + 1'b1;
      end
      if (bno_q != `SSF_BYTE_NO_DATA) begin
        bno_d = bno_q + 1'b1;
      end
      if (!in_ready) begin
        ovf_d = 1'b1;
      end
    end
    oe_n_d = (st_d != SSF_SEL) ? 1'b1 : (fall ? 1'b0 : oe_n_q);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= SSF_IDLE;
      oe_n_q <= 1'b1;
      bit_q <= '0;
      shin_q <= '0;
      shout_q <= '0;
      bno_q <= '0;
      amsb_q <= 1'b0;
      addr_q <= '0;
      sdo_q <= 1'b0;
      take_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      st_q <= st_d;
      oe_n_q <= oe_n_d;
      bit_q <= bit_d;
      shin_q <= shin_d;
      shout_q <= shout_d;
      bno_q <= bno_d;
      amsb_q <= amsb_d;
      addr_q <= addr_d;
      sdo_q <= sdo_d;
      take_q <= take_d;
      ovf_q <= ovf_d;
    end
  end

  // first completed byte is the instruction
  assign item = '{first: (bno_q == '0), data: new_byte};
  assign push = byte_done && in_ready;

  ssf_fifo #(.WIDTH($bits(ssf_rx_t)), .DEPTH(`SSF_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data(item),
    .in_valid(byte_done),
    .in_ready(in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  assign sdo_o = sdo_q;
  assign sdo_oe_n = oe_n_q;
  assign tx_take = take_q;
  assign addr = addr_q;
  assign selected = st_q[1]; // one-hot bit of the selected state
  assign overflow = ovf_q;

  // check helper: rises counted since selection, held at 8
  logic [3:0] nrise_q, nrise_d;
  always_comb begin
    nrise_d = nrise_q;
    if (st_q == SSF_IDLE && st_d == SSF_SEL) begin
      nrise_d = 4'h0;
    end else if (rise && st_q == SSF_SEL && nrise_q != 4'h8) begin
      nrise_d = nrise_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      nrise_q <= 4'h0;
    end else begin
      nrise_q <= nrise_d;
    end
  end

  // checks on the front end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_rise_capture: assert property ((rise && st_q == SSF_SEL && !sel_rise && !sel_fall)
    |=> shin_q[0] == $past(sdi_s)) else $error("input bit not captured on rise");
  a_out_on_fall: assert property ($changed(sdo_q) |-> $past(fall))
    else $error("output changed without clock fall");
  a_select_low: assert property ((st_q == SSF_IDLE && sel_fall && !sck_s)
    |=> (st_q == SSF_SEL && bit_q == '0)) else $error("select not taken or unaligned");
  a_deselect_low: assert property ((sel_rise && !sck_s) |=> st_q == SSF_IDLE)
    else $error("deselect not taken");
  a_release_out: assert property ((st_q != SSF_SEL) |-> oe_n_q)
    else $error("output driven while deselected");
  a_reset_state: assert property ($past(!rstn) |-> (st_q == SSF_IDLE && oe_n_q))
    else $error("not deselected after reset");
  a_ignore_high: assert property ((sck_s && (sel_rise || sel_fall)) |=> $stable(st_q))
    else $error("select change taken with clock high");
  a_page_hold: assert property ((byte_done && bno_q == `SSF_BYTE_NO_DATA)
    |=> (addr_q.page == $past(addr_q.page) && addr_q.idx == $past(addr_q.idx) + 1'b1))
    else $error("address left its page");
  a_first_instr: assert property (push |-> (item.first == (nrise_q == 4'h7)))
    else $error("instruction flag not on the eighth bit");

  c_select: cover property (st_q == SSF_IDLE ##1 st_q == SSF_SEL);
  c_full_byte: cover property (push && item.first);
  c_overflow: cover property (byte_done && !in_ready);
  c_deselect: cover property (st_q == SSF_SEL ##1 st_q == SSF_IDLE);
endmodule // ssf_front

// ===== rtl/ssf_pkg.sv
// types of the select/shift front end
// assumes ssf_cfg.svh on the include path
`include "ssf_cfg.svh"
package ssf_pkg;
  // one received byte, flagged when it is the instruction byte
  typedef struct packed {
    logic first;
    logic [`SSF_BYTE_W-1:0] data;
  } ssf_rx_t;
  // array address: page index and byte within page
  typedef struct packed {
    logic [`SSF_PAGE_W-1:0] page;
    logic [`SSF_IDX_W-1:0] idx;
  } ssf_addr_t;
  // selection state, one-hot
  typedef enum logic [1:0] {
    SSF_IDLE = 2'h1,
    SSF_SEL = 2'h2
  } ssf_state_t;
endpackage

// ===== testbench/ssf_spi_ctrl.sv
// spi controller model driving the front end's pins
// assumes the bench clock; pins change just after its rising edges
`timescale 1ns/10ps
module ssf_spi_ctrl (
  input wire logic clk_sys,
  output logic sck,
  output logic sel_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sck = 1'b0;
    sel_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic set_sel(input logic v);
    @(posedge clk_sys);
    sel_n <= v;
    if (v) sdi <= ~sdi; // released data line no longer holds its value
    wt(6);
  endtask
  // select change while clock high
  task automatic glitch(input logic v);
    sck <= 1'b1;
    wt(5);
    sel_n <= v;
    wt(5);
    sck <= 1'b0;
    wt(6);
  endtask
  // msb first, output sampled at each rise
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sdi <= tx[i];
      wt(5);
      sck <= 1'b1;
      rx[i] = sdo;
      wt(5);
      sck <= 1'b0;
    end
    wt(6);
  endtask
endmodule // ssf_spi_ctrl

// ===== testbench/test_serial_eeprom_select_shift_front.sv
// self-checking bench for the select/shift front end
// assumes the design files and the controller model compiled first
`timescale 1ns/10ps
module test_serial_eeprom_select_shift_front;
  import ssf_pkg::*;
  logic clk_sys;
  logic rstn;
  logic sck, sel_n, sdi, sdo_o, sdo_oe_n, sdo_w, rx_valid, tx_take, selected, overflow;
  logic rx_ready;
  logic hold = 1'b0;
  logic [7:0] tx_byte;
  ssf_rx_t rx_data;
  ssf_addr_t addr;
  int seed = 32'h8BFD;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [8:0] expq[$];
  logic [7:0] txq[$];
  // clock: unknown for the first half period, then inverted each half period
  always #5 clk_sys = (clk_sys !== 1'b1);
  // shared output line with pull-up: released line reads high
  assign sdo_w = sdo_o | sdo_oe_n;
  ssf_front dut (.clk_sys(clk_sys), .rstn(rstn), .sck_i(sck), .sel_n_i(sel_n), .sdi_i(sdi),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_byte(tx_byte), .tx_take(tx_take), .addr(addr),
    .selected(selected), .overflow(overflow));
  ssf_spi_ctrl u_ctl (.clk_sys(clk_sys), .sck(sck), .sel_n(sel_n), .sdi(sdi), .sdo(sdo_w));
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // user side: random ready, tx bytes refreshed, popped entries compared
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rx_ready <= hold ? 1'b0 : 1'($random(seed));
    if (tx_take === 1'b1) begin
      txq.push_back(tx_byte);
    end
    // fresh tx byte during reset and after each load
    if (rstn !== 1'b1 || tx_take === 1'b1) begin
      tx_byte <= 8'($random(seed));
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      chk("rx_data", expq.size() > 0 ? 10'(expq[0]) : 10'h3FF, 10'(rx_data));
      if (expq.size() > 0) void'(expq.pop_front());
    end
    if (cyc == 40000) begin
      errors++;
      final_report();
    end
  end
  // expected address: instruction bit 3, address byte, one step per data byte
  function automatic logic [9:0] exp_addr(input logic [7:0] ins, input logic [7:0] a,
    input int n);
    return {1'b0, ins[3], a[7:4], 4'(a[3:0] + n - 2)};
  endfunction
  // one selected frame of n bytes, then deselect
  task automatic frame(input int n);
    logic [7:0] b, r, a, ins;
    a = 8'h00;
    ins = 8'h00;
    txq.delete();
    u_ctl.set_sel(1'b0);
    chk("selected", 10'h1, 10'(selected));
    for (int k = 0; k < n; k++) begin
      b = 8'($random(seed));
      if (k == 0) ins = b;
      if (k == 1) a = b;
      if (expq.size() < 8) expq.push_back({k == 0, b});
      u_ctl.xfer(b, 8, r);
      // first bit reads the pull-up, rest padding
      chk("sdo_byte", 10'(k == 0 ? 8'h80 : txq[k-1]), 10'(r));
    end
    chk("addr", exp_addr(ins, a, n), 10'(addr));
    u_ctl.set_sel(1'b1);
    chk("oe_n", 10'h1, 10'(sdo_oe_n));
    chk("deselected", 10'h0, 10'(selected));
  endtask
  initial begin
    logic [7:0] r;
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("oe_n_reset", 10'h1, 10'(sdo_oe_n));
    chk("sel_reset", 10'h0, 10'(selected));
    $display("test reset done");
    for (int i = 0; i < 6; i++) frame(2 + {$random(seed)} % 6);
    frame(17);
    $display("test frames done");
    u_ctl.glitch(1'b0);
    chk("sel_glitch", 10'h0, 10'(selected));
    u_ctl.set_sel(1'b1);
    u_ctl.set_sel(1'b0);
    u_ctl.glitch(1'b1);
    chk("desel_glitch", 10'h1, 10'(selected));
    u_ctl.set_sel(1'b0);
    u_ctl.set_sel(1'b1);
    $display("test glitch done");
    u_ctl.xfer(8'hA5, 8, r);
    chk("sdo_released", 10'hFF, 10'(r));
    u_ctl.set_sel(1'b0);
    u_ctl.xfer(8'h5A, 3, r);
    u_ctl.set_sel(1'b1);
    frame(2);
    $display("test partial done");
    hold <= 1'b1;
    frame(10);
    chk("overflow", 10'h1, 10'(overflow));
    hold <= 1'b0;
    for (int i = 0; i < 400 && expq.size() > 0; i++) @(posedge clk_sys);
    u_ctl.set_sel(1'b0);
    chk("overflow_clr", 10'h0, 10'(overflow));
    u_ctl.set_sel(1'b1);
    chk("drained", 10'h0, 10'(rx_valid));
    $display("test overflow done");
    final_report();
  end
endmodule // test_serial_eeprom_select_shift_front
